// ===== include/dbg_regs_pkg.sv
// package: command codes, bit positions and reset values of the debug registers
// assumes: shared by the register block and its helper modules
package dbg_regs_pkg;
    localparam logic [7:0]  CMD_READ_STATUS   = 8'he4;
    localparam logic [7:0]  CMD_WRITE_CONTROL = 8'hc4;
    localparam logic [7:0]  CMD_READ_MATCH    = 8'he2;
    localparam logic [7:0]  CMD_WRITE_MATCH   = 8'hc2;
    localparam logic [7:0]  CMD_BACKGROUND    = 8'h90;
    localparam int          BIT_PERMIT        = 7;
    localparam int          BIT_ACTIVE        = 6;
    localparam int          BIT_BKPT_EN       = 5;
    localparam int          BIT_FORCE_TAG     = 4;
    localparam int          BIT_CLK_SEL       = 3;
    localparam int          BIT_WAIT_STOP     = 2;
    localparam int          BIT_WS_FAIL       = 1;
    localparam int          BIT_DV_FAIL       = 0;
    localparam logic [7:0]  CONTROL_RESET     = 8'h00;
    localparam logic [15:0] MATCH_RESET       = 16'h0000;
    localparam int          SYNC_STAGES       = 2;
endpackage

// ===== verilog/reset_sync.sv
// file: reset synchroniser, asynchronous assert and two-stage release
// assumes: rst_n_i is active low and may be asynchronous to clk_i
`timescale 1ns/1ps
module reset_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    output logic      rst_n_o
);
    logic [dbg_regs_pkg::SYNC_STAGES-1:0] sync_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[dbg_regs_pkg::SYNC_STAGES-2:0], 1'b1};
        end
    end

    assign rst_n_o = sync_q[dbg_regs_pkg::SYNC_STAGES-1];
endmodule // reset_sync

// ===== verilog/bkpt_match.sv
// file: breakpoint comparator with forced and tagged request generation
// assumes: cpu address and fetch strobes are synchronous to clk_i
`timescale 1ns/1ps
module bkpt_match #(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              enable_i,
    input  wire logic              force_sel_i,
    input  wire logic [ADDR_W-1:0] match_i,
    input  wire logic [ADDR_W-1:0] cpu_addr_i,
    input  wire logic              cpu_access_i,
    input  wire logic              cpu_fetch_i,
    input  wire logic              insn_boundary_i,
    output logic                   force_req_o,
    output logic                   tag_o
);
    logic hit;
    logic pending_q;
    logic pending_d;

    // comparator gated by enable
    assign hit = enable_i && cpu_access_i && (cpu_addr_i == match_i);

    // forced: remember hit until next boundary, any address
    assign pending_d = (pending_q || (hit && force_sel_i)) && !insn_boundary_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= enable_i && force_sel_i && pending_d;
        end
    end

    assign force_req_o = enable_i && force_sel_i && insn_boundary_i && (pending_q || hit);
    // tagged: mark fetched opcode on match
    assign tag_o = hit && !force_sel_i && cpu_fetch_i;
endmodule // bkpt_match

// ===== verilog/debug_status_breakpoint_regs.sv
// file: status/control and breakpoint match registers of the serial debug controller
// assumes: a serial front end decodes command bytes and data into cmd_* strobes
// Contract
// - two registers: 8-bit status/control and 16-bit breakpoint match address.
// - status/control reached only by read-status and write-control commands.
// - permit bit write refused while active debug mode is in force.
// - active, wait/stop, wait/stop failure and data-valid bits are read-only.
// - clock select bit always writable, resets 0 for alternate clock.
// - host sets permit early; it stays until a normal reset. Here a write-control carrying permit 0 in run mode also clears it.
// - permit 0 blocks active mode; non-intrusive commands still run.
// - active bit reads 1 in active debug mode, 0 while running.
// - breakpoint enable 0 raises no breakpoint, ignores select and match.
// - force select 1: address match forces active mode at next boundary.
// - force select 0: match tags opcode; enter only if it reaches queue end.
// - wait/stop bit reads 1 in wait/stop or entered active from it.
// - background command still pulls processor out of wait or stop.
// - wait/stop failure set when memory command collides with wait/stop.
// - data-valid failure bit unused, reads 0.
// - match register reached only by read/write breakpoint commands.
// - read-status code e4 returns status; write-control code c4 carries control.
// - read-breakpoint code e2 returns match; write-breakpoint code c2 carries it.
// - breakpoint enable is 0 after reset.
`timescale 1ns/1ps
module debug_status_breakpoint_regs #(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // decoded serial command: code, strobe and data
    input  wire logic              cmd_valid_i,
    input  wire logic [7:0]        cmd_code_i,
    input  wire logic [15:0]       cmd_wdata_i,
    output logic [15:0]            cmd_rdata_o,
    output logic                   cmd_rvalid_o,
    output logic                   cmd_active_only_o,
    // processor side
    input  wire logic [ADDR_W-1:0] cpu_addr_i,
    input  wire logic              cpu_access_i,
    input  wire logic              cpu_fetch_i,
    input  wire logic              insn_boundary_i,
    input  wire logic              tagged_at_queue_end_i,
    input  wire logic              cpu_wait_stop_i,
    input  wire logic              go_cmd_i,
    input  wire logic              mem_cmd_fail_ws_i,
    input  wire logic              mem_cmd_ok_i,
    output logic                   enter_debug_o,
    output logic                   debug_active_flag_o,
    output logic                   tag_o,
    output logic                   wake_from_wait_stop_o,
    output logic                   comm_clock_select_o
);
    typedef enum logic [0:0] {RUN, ACTIVE} mode_type;

    // elaboration check: match register width is fixed
    if (ADDR_W != 16) begin : g_width_check
        $error("match register is 16 bits wide");
    end

    logic               rst_n;
    mode_type           mode_q;
    mode_type           mode_d;
    logic               debug_mode_permit_q;
    logic               breakpoint_enable_q;
    logic               force_tag_select_q;
    logic               comm_clock_select_q;
    logic               wait_stop_status_q;
    logic               wait_stop_failure_q;
    logic [15:0]        breakpoint_match_address_q;
    logic [15:0]        rdata_q;
    logic               rvalid_q;
    logic               rd_status;
    logic               wr_control;
    logic               rd_match;
    logic               wr_match;
    logic               bkgd_cmd;
    logic               force_req;
    logic               bp_entry;
    logic               entry;
    logic               leave;
    logic               permit_d;
    logic               ws_d;
    logic               wsf_d;
    logic [7:0]         status_byte;

    reset_sync u_reset_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .rst_n_o (rst_n)
    );

    // command decode
    assign rd_status  = cmd_valid_i && (cmd_code_i == dbg_regs_pkg::CMD_READ_STATUS);
    assign wr_control = cmd_valid_i && (cmd_code_i == dbg_regs_pkg::CMD_WRITE_CONTROL);
    assign rd_match   = cmd_valid_i && (cmd_code_i == dbg_regs_pkg::CMD_READ_MATCH);
    assign wr_match   = cmd_valid_i && (cmd_code_i == dbg_regs_pkg::CMD_WRITE_MATCH);
    assign bkgd_cmd   = cmd_valid_i && (cmd_code_i == dbg_regs_pkg::CMD_BACKGROUND);

    bkpt_match #(
        .ADDR_W (ADDR_W)
    ) u_bkpt_match (
        .clk_i           (clk_i),
        .rst_n_i         (rst_n),
        .enable_i        (breakpoint_enable_q && (mode_q == RUN)),
        .force_sel_i     (force_tag_select_q),
        .match_i         (breakpoint_match_address_q),
        .cpu_addr_i      (cpu_addr_i),
        .cpu_access_i    (cpu_access_i),
        .cpu_fetch_i     (cpu_fetch_i),
        .insn_boundary_i (insn_boundary_i),
        .force_req_o     (force_req),
        .tag_o           (tag_o)
    );

    // tagged entry only when the tagged opcode reaches the queue end
    assign bp_entry = force_req
                   || (breakpoint_enable_q && !force_tag_select_q
                       && tagged_at_queue_end_i);
    // active entry needs the permit bit
    assign entry = debug_mode_permit_q && (mode_q == RUN)
                && (bkgd_cmd || bp_entry);
    assign leave = (mode_q == ACTIVE) && go_cmd_i;

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            RUN: begin
                if (entry) begin
                    mode_d = ACTIVE;
                end
            end
            ACTIVE: begin
                if (leave) begin
                    mode_d = RUN;
                end
            end
        endcase
    end

    // permit write refused while active
    assign permit_d = (wr_control && (mode_q == RUN))
                    ? cmd_wdata_i[dbg_regs_pkg::BIT_PERMIT]
                    : debug_mode_permit_q;

    // wait/stop: live in run, held from entry while active, live again on leave
    assign ws_d = ((mode_q == RUN) || leave) ? cpu_wait_stop_i
                                              : wait_stop_status_q;

    // failure: set wins over clear by a successful memory command
    assign wsf_d = mem_cmd_fail_ws_i
                || (wait_stop_failure_q && !mem_cmd_ok_i);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mode_q              <= RUN;
            debug_mode_permit_q <= dbg_regs_pkg::CONTROL_RESET[dbg_regs_pkg::BIT_PERMIT];
            breakpoint_enable_q <= dbg_regs_pkg::CONTROL_RESET[dbg_regs_pkg::BIT_BKPT_EN];
            force_tag_select_q  <= dbg_regs_pkg::CONTROL_RESET[dbg_regs_pkg::BIT_FORCE_TAG];
            comm_clock_select_q <= dbg_regs_pkg::CONTROL_RESET[dbg_regs_pkg::BIT_CLK_SEL];
            wait_stop_status_q  <= 1'b0;
            wait_stop_failure_q <= 1'b0;
        end else begin
            mode_q              <= mode_d;
            debug_mode_permit_q <= permit_d;
            wait_stop_status_q  <= ws_d;
            wait_stop_failure_q <= wsf_d;
            // writable control bits; status bits never taken from data
            if (wr_control) begin
                breakpoint_enable_q <= cmd_wdata_i[dbg_regs_pkg::BIT_BKPT_EN];
                force_tag_select_q  <= cmd_wdata_i[dbg_regs_pkg::BIT_FORCE_TAG];
                comm_clock_select_q <= cmd_wdata_i[dbg_regs_pkg::BIT_CLK_SEL];
            end
        end
    end

    // match register, serial access only
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            breakpoint_match_address_q <= dbg_regs_pkg::MATCH_RESET;
        end else if (wr_match) begin
            breakpoint_match_address_q <= cmd_wdata_i;
        end
    end

    // status byte assembly
    always_comb begin
        status_byte = 8'h00;
        status_byte[dbg_regs_pkg::BIT_PERMIT]    = debug_mode_permit_q;
        status_byte[dbg_regs_pkg::BIT_ACTIVE]    = (mode_q == ACTIVE);
        status_byte[dbg_regs_pkg::BIT_BKPT_EN]   = breakpoint_enable_q;
        status_byte[dbg_regs_pkg::BIT_FORCE_TAG] = force_tag_select_q;
        status_byte[dbg_regs_pkg::BIT_CLK_SEL]   = comm_clock_select_q;
        status_byte[dbg_regs_pkg::BIT_WAIT_STOP] = wait_stop_status_q;
        status_byte[dbg_regs_pkg::BIT_WS_FAIL]   = wait_stop_failure_q;
        status_byte[dbg_regs_pkg::BIT_DV_FAIL]   = 1'b0;
    end

    // read data registered, one cycle after the command
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_status || rd_match;
            if (rd_status) begin
                rdata_q <= {8'h00, status_byte};
            end else if (rd_match) begin
                rdata_q <= breakpoint_match_address_q;
            end
        end
    end

    assign cmd_rdata_o           = rdata_q;
    assign cmd_rvalid_o          = rvalid_q;
    assign cmd_active_only_o     = (mode_q == ACTIVE);
    assign enter_debug_o         = entry;
    assign debug_active_flag_o   = (mode_q == ACTIVE);
    assign wake_from_wait_stop_o = entry && bkgd_cmd && cpu_wait_stop_i;
    assign comm_clock_select_o   = comm_clock_select_q;
endmodule // debug_status_breakpoint_regs

// ===== test/dbg_regs_chk.sv
// file: port checker of the debug status and breakpoint registers
// assumes: bound to debug_status_breakpoint_regs, one clock domain
`timescale 1ns/1ps
module dbg_regs_chk (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [15:0] cmd_wdata_i,
    input  wire logic [15:0] cmd_rdata_o,
    input  wire logic        cmd_rvalid_o,
    input  wire logic        enter_debug_o,
    input  wire logic        debug_active_flag_o,
    input  wire logic        tag_o,
    input  wire logic        wake_from_wait_stop_o,
    input  wire logic        comm_clock_select_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire rd_stat  = cmd_valid_i && cmd_code_i == dbg_regs_pkg::CMD_READ_STATUS;
    wire rd_match = cmd_valid_i && cmd_code_i == dbg_regs_pkg::CMD_READ_MATCH;
    wire wr_ctrl  = cmd_valid_i && cmd_code_i == dbg_regs_pkg::CMD_WRITE_CONTROL;
    property p_read_answer; (rd_stat || rd_match) |=> cmd_rvalid_o; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_rvalid_cause; cmd_rvalid_o |-> $past(rd_stat || rd_match); endproperty
    a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray rvalid");
    property p_status_fields;
        rd_stat |=> cmd_rdata_o[15:8] == 8'h00 && !cmd_rdata_o[0]
            && cmd_rdata_o[6] == $past(debug_active_flag_o)
            && cmd_rdata_o[3] == $past(comm_clock_select_o);
    endproperty
    a_status_fields: assert property (p_status_fields) else $error("bad status");
    property p_clksel_write; wr_ctrl |=> comm_clock_select_o == $past(cmd_wdata_i[3]); endproperty
    a_clksel_write: assert property (p_clksel_write) else $error("clksel not written");
    property p_clksel_hold; !wr_ctrl |=> $stable(comm_clock_select_o); endproperty
    a_clksel_hold: assert property (p_clksel_hold) else $error("clksel changed");
    property p_enter_active; enter_debug_o |=> debug_active_flag_o; endproperty
    a_enter_active: assert property (p_enter_active) else $error("active not set");
    property p_no_tag_active; debug_active_flag_o |-> !tag_o; endproperty
    a_no_tag_active: assert property (p_no_tag_active) else $error("tag while active");
    property p_wake_enters; wake_from_wait_stop_o |-> enter_debug_o; endproperty
    a_wake_enters: assert property (p_wake_enters) else $error("wake without entry");
endmodule // dbg_regs_chk
bind debug_status_breakpoint_regs dbg_regs_chk u_dbg_regs_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o), .cmd_rvalid_o(cmd_rvalid_o),
    .enter_debug_o(enter_debug_o), .debug_active_flag_o(debug_active_flag_o),
    .tag_o(tag_o), .wake_from_wait_stop_o(wake_from_wait_stop_o),
    .comm_clock_select_o(comm_clock_select_o));

// ===== test/debug_host.sv
// file: debug host model issuing decoded serial commands
// assumes: send is called at falling clk_i edges
`timescale 1ns/1ps
module debug_host (
    input  wire logic        clk_i,
    output logic             cmd_valid_o,
    output logic [7:0]       cmd_code_o,
    output logic [15:0]      cmd_wdata_o,
    input  wire logic [15:0] cmd_rdata_i,
    input  wire logic        cmd_rvalid_i
);
    logic [15:0] rd_q;
    logic        rv_q;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o  = 8'h00;
        cmd_wdata_o = 16'h0000;
    end
    // one command, then idle lines show inverted last value
    task automatic send(input logic [7:0] code, input logic [15:0] data);
        cmd_valid_o = 1'b1;
        cmd_code_o  = code;
        cmd_wdata_o = data;
        @(negedge clk_i);
        rd_q        = cmd_rdata_i;
        rv_q        = cmd_rvalid_i;
        cmd_valid_o = 1'b0;
        cmd_code_o  = ~code;
        cmd_wdata_o = ~data;
        @(negedge clk_i);
    endtask
endmodule // debug_host

// ===== test/testbench.sv
// file: self-checking bench of the debug status and breakpoint registers
// assumes: debug_host drives the command port, bench drives the cpu side
`timescale 1ns/1ps
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        acc = 1'b0, fetch = 1'b0, bnd = 1'b0, qend = 1'b0;
    logic        wst = 1'b0, go = 1'b0, fail = 1'b0, ok = 1'b0;
    logic        valid, rvalid, aonly, enter, active, tag, wake, clksel;
    logic [7:0]  code;
    logic [15:0] wdata, rdata, addr = 16'h0000;
    logic [47:0] rows [5];
    int          miscompares = 0, check_count = 0, cyc = 0;
    always #20 clk_i = ~clk_i;
    debug_status_breakpoint_regs u_debug_status_breakpoint_regs (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(valid), .cmd_code_i(code),
        .cmd_wdata_i(wdata), .cmd_rdata_o(rdata), .cmd_rvalid_o(rvalid),
        .cmd_active_only_o(aonly), .cpu_addr_i(addr), .cpu_access_i(acc),
        .cpu_fetch_i(fetch), .insn_boundary_i(bnd), .tagged_at_queue_end_i(qend),
        .cpu_wait_stop_i(wst), .go_cmd_i(go), .mem_cmd_fail_ws_i(fail), .mem_cmd_ok_i(ok),
        .enter_debug_o(enter), .debug_active_flag_o(active), .tag_o(tag),
        .wake_from_wait_stop_o(wake), .comm_clock_select_o(clksel));
    debug_host u_debug_host (.clk_i(clk_i), .cmd_valid_o(valid), .cmd_code_o(code),
        .cmd_wdata_o(wdata), .cmd_rdata_i(rdata), .cmd_rvalid_i(rvalid));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [15:0] d);
        u_debug_host.send(c, d);
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        u_debug_host.send(c, 16'h0000);
        chk(u_debug_host.rd_q, exp);
        chk({15'h0000, u_debug_host.rv_q}, 16'h0001);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_i);
        s = 1'b0;
    endtask
    task automatic do_reset;
        rst_n_i = 1'b0;
        repeat (12) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        rows[0] = {8'hc4, 16'h0008, 8'he4, 16'h0008};
        rows[1] = {8'hc4, 16'h003f, 8'he4, 16'h0038};
        rows[2] = {8'hc4, 16'h0040, 8'he4, 16'h0000};
        rows[3] = {8'hc2, 16'ha55a, 8'he2, 16'ha55a};
        rows[4] = {8'hc2, 16'hffff, 8'he2, 16'hffff};
        do_reset();
        rd(8'he4, 16'h0000);
        rd(8'he2, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            cmd(rows[i][47:40], rows[i][39:24]);
            rd(rows[i][23:16], rows[i][15:0]);
        end
        // background refused without permit
        fork
            cmd(8'h90, 16'h0000);
            #1 chk(enter, 16'h0000);
        join
        chk(active, 16'h0000);
        chk(aonly, 16'h0000);
        cmd(8'hc4, 16'h0080);
        cmd(8'h90, 16'h0000);
        rd(8'he4, 16'h00c0);
        cmd(8'hc4, 16'h0008);
        rd(8'he4, 16'h00c8);
        chk(clksel, 16'h0001);
        cmd(8'hc2, 16'h1234);
        pulse(go);
        rd(8'he4, 16'h0088);
        // forced breakpoint at next boundary
        cmd(8'hc4, 16'h00b0);
        addr = 16'h1234;
        acc = 1'b1;
        @(negedge clk_i);
        acc = 1'b0;
        chk(active, 16'h0000);
        pulse(bnd);
        chk(active, 16'h0001);
        chk(aonly, 16'h0001);
        pulse(go);
        // tagged opcode enters at queue end
        cmd(8'hc4, 16'h00a0);
        acc = 1'b1;
        fetch = 1'b1;
        #1 chk(tag, 16'h0001);
        @(negedge clk_i);
        acc = 1'b0;
        fetch = 1'b0;
        chk(active, 16'h0000);
        pulse(qend);
        chk(active, 16'h0001);
        pulse(go);
        // breakpoint disabled ignores select and match
        cmd(8'hc4, 16'h0080);
        acc = 1'b1;
        fetch = 1'b1;
        #1 chk(tag, 16'h0000);
        @(negedge clk_i);
        cmd(8'hc4, 16'h0090);
        acc = 1'b1;
        fetch = 1'b1;
        #1 chk(tag, 16'h0000);
        @(negedge clk_i);
        acc = 1'b0;
        fetch = 1'b0;
        pulse(bnd);
        pulse(qend);
        chk(active, 16'h0000);
        // wait/stop, background wake, failure and recovery
        wst = 1'b1;
        @(negedge clk_i);
        rd(8'he4, 16'h0094);
        fork
            cmd(8'h90, 16'h0000);
            begin
                #1 chk(wake, 16'h0001);
                chk(enter, 16'h0001);
            end
        join
        wst = 1'b0;
        rd(8'he4, 16'h00d4);
        pulse(fail);
        rd(8'he4, 16'h00d6);
        fail = 1'b1;
        ok = 1'b1;
        @(negedge clk_i);
        fail = 1'b0;
        ok = 1'b0;
        rd(8'he4, 16'h00d6);
        pulse(ok);
        rd(8'he4, 16'h00d4);
        pulse(go);
        rd(8'he4, 16'h0090);
        do_reset();
        rd(8'he4, 16'h0000);
        chk(clksel, 16'h0000);
        stop_test();
    end
endmodule // testbench
